// ---- rtl/mask_route.sv ----
// per-filter mask selection for filters 4 to 7
// assumes mask codes come straight from the mask select register
`timescale 1ns/1ps
module mask_route
  import prog_buf_pkg::*;
(
  // selection input
  input wire logic [7:0] mask_select_in,
  input wire logic enhanced_in,
  // per-filter routing, one 2-bit code per filter, 11 = unmasked
  output logic [7:0] filter_route_out
);
  // ------------------------------------------------------------
  // routing
  // ------------------------------------------------------------
  // legacy mode has no selection: all filters fall back to mask 0
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (enhanced_in) begin
        filter_route_out[2*i +: 2] = mask_select_in[2*i +: 2];
      end else begin
        filter_route_out[2*i +: 2] = MSEL_MASK0;
      end
    end
  end
endmodule

// ---- rtl/prog_buf_pkg.sv ----
// package for the programmable message buffer block
// holds register indices, field positions, reset values and bus carriers
package prog_buf_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int NUM_BUFS = 6;
  localparam int BUF_BYTES = 14;
  localparam int BUF_AW = 4;
  // ------------------------------------------------------------
  // word addresses (avalon word index, byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_MAIN_CTRL = 8'h00;
  localparam logic [7:0] IDX_DIR_SEL = 8'h01;
  localparam logic [7:0] IDX_MASK_SEL = 8'h02;
  localparam logic [7:0] IDX_IRQ_EN = 8'h03;
  localparam logic [7:0] IDX_STATUS = 8'h04;
  localparam logic [7:0] IDX_BUF_BASE = 8'h10;
  localparam logic [7:0] BUF_STRIDE = 8'h10;
  // byte positions inside one buffer window
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STD_ID_LOW = 4'h2;
  localparam logic [3:0] OFS_LENGTH = 4'h5;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_LSB = 5;
  localparam int FIFO_PTR_LSB = 0;
  localparam int CTL_TX_REQUEST = 3;
  localparam int CTL_AUTO_REPLY = 2;
  localparam int CTL_FULL = 7;
  localparam int IE_TXB2 = 4;
  localparam int IE_TXB1 = 3;
  localparam int IE_TXB0 = 2;
  localparam int IE_RXB0 = 0;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_SEL_RST = 8'h05;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [5:0] DIR_SEL_RST = 6'h00;
  // mask choice codes
  localparam logic [1:0] MSEL_MASK0 = 2'h0;
  localparam logic [1:0] MSEL_MASK1 = 2'h1;
  localparam logic [1:0] MSEL_FILT15 = 2'h2;
  localparam logic [1:0] MSEL_NONE = 2'h3;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00,
    MODE_ENHANCED = 2'b01,
    MODE_FIFO = 2'b10
  } can_mode_e;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_e;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } av_req_s;
  // event from the protocol engine
  typedef struct packed {
    logic valid;
    logic [2:0] buf_idx;
  } engine_evt_s;
endpackage

// ---- rtl/prog_buffers.sv ----
// six programmable message buffers with auto remote reply
// assumes a protocol engine on the same clock that reports events as pulses
`timescale 1ns/1ps
module prog_buffers
  import prog_buf_pkg::*;
#(
  parameter int NBUF = NUM_BUFS
)(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // protocol engine events
  input wire logic rtr_hit_in,
  input wire logic [2:0] rtr_buf_in,
  input wire logic tx_done_in,
  input wire logic [2:0] tx_buf_in,
  input wire logic rx_load_in,
  input wire logic [2:0] rx_buf_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic [3:0] rx_byte_idx_in,
  // to the protocol engine and interrupt logic
  output logic [5:0] tx_pending_out,
  output logic [5:0] tx_done_flags_out,
  output logic [5:0] rx_full_out,
  output logic [7:0] filter_route_out,
  output logic tx_irq_out
);
  // ------------------------------------------------------------
  // storage and control registers
  // ------------------------------------------------------------
  logic [7:0] mem_q [NBUF][BUF_BYTES];
  logic [7:0] main_ctrl_q;
  logic [5:0] dir_sel_q;
  logic [7:0] mask_sel_q;
  logic [7:0] irq_en_q;
  logic [5:0] done_q;
  logic [31:0] rdata_q;
  logic answer_now;
  logic lock_seen_q;
  logic [7:0] lock_old_q;
  logic [2:0] lock_buf_q;
  logic [3:0] lock_ofs_q;
  bus_state_e state_q;
  can_mode_e mode;
  logic enhanced;
  av_req_s req;
  logic [2:0] wbuf;
  logic [3:0] wofs;
  logic buf_hit;
  logic buf_locked;
  logic take_write;
  logic take_read;
  logic [2:0] fifo_slot;

  assign req = '{avs_read_in, avs_write_in, avs_address_in, avs_writedata_in};
  assign mode = can_mode_e'(main_ctrl_q[MODE_LSB +: 2]);
  assign enhanced = (mode == MODE_ENHANCED) || (mode == MODE_FIFO);
  assign fifo_slot = main_ctrl_q[FIFO_PTR_LSB +: 3];

  // decode buffer index, valid only inside a 14-byte window
  function automatic logic in_buf(input logic [7:0] a);
    in_buf = (a >= IDX_BUF_BASE) && (a[3:0] < 4'(BUF_BYTES))
      && (((a - IDX_BUF_BASE) >> 4) < 8'(NBUF));
  endfunction

  // mode 2 sends every bus access to a receive buffer through the fifo pointer
  assign wbuf = (mode == MODE_FIFO && !dir_sel_q[3'((req.address - IDX_BUF_BASE) >> 4)])
    ? fifo_slot : 3'((req.address - IDX_BUF_BASE) >> 4);
  assign wofs = req.address[3:0];
  assign buf_hit = enhanced && in_buf(req.address);
  assign buf_locked = mem_q[wbuf][OFS_CONTROL][CTL_TX_REQUEST] && dir_sel_q[wbuf];
  // writes land on the edge where waitrequest is low; reads fetch one edge earlier
  assign take_write = (state_q == BUS_ANSWER) && req.write;
  assign take_read = (state_q == BUS_IDLE) && req.read;

  // ------------------------------------------------------------
  // bus handshake: one wait cycle then the answer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q <= BUS_IDLE;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (req.read || req.write) begin
            state_q <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          state_q <= BUS_IDLE;
        end
        default: begin
          state_q <= BUS_IDLE;
        end
      endcase
    end
  end
  assign answer_now = (state_q == BUS_ANSWER);
  assign avs_waitrequest_out = (req.read || req.write) && !answer_now;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      main_ctrl_q <= 8'h00;
      dir_sel_q <= DIR_SEL_RST;
      mask_sel_q <= MASK_SEL_RST;
      irq_en_q <= IRQ_EN_RST;
    end else if (take_write) begin
      case (req.address)
        IDX_MAIN_CTRL: main_ctrl_q <= req.writedata[7:0];
        IDX_DIR_SEL: dir_sel_q <= req.writedata[5:0];
        IDX_MASK_SEL: begin
          if (enhanced) begin
            mask_sel_q <= req.writedata[7:0];
          end
        end
        IDX_IRQ_EN: irq_en_q <= req.writedata[7:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // buffer storage: firmware writes and engine updates
  // ------------------------------------------------------------
  // hardware sets win over a firmware write in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      for (int b = 0; b < NBUF; b++) begin
        for (int k = 0; k < BUF_BYTES; k++) begin
          mem_q[b][k] <= 8'h00;
        end
      end
    end else begin
      if (take_write && buf_hit && !buf_locked) begin
        mem_q[wbuf][wofs] <= req.writedata[7:0];
      end
      if (rx_load_in && enhanced && rx_buf_in < 3'(NBUF) && !dir_sel_q[rx_buf_in]
          && !mem_q[rx_buf_in][OFS_CONTROL][CTL_FULL]) begin
        mem_q[rx_buf_in][rx_byte_idx_in] <= rx_byte_in;
        if (rx_byte_idx_in == OFS_CONTROL) begin
          mem_q[rx_buf_in][OFS_CONTROL] <= rx_byte_in | 8'h80;
        end
      end
      if (rtr_hit_in && enhanced && rtr_buf_in < 3'(NBUF) && dir_sel_q[rtr_buf_in]
          && mem_q[rtr_buf_in][OFS_CONTROL][CTL_AUTO_REPLY]) begin
        mem_q[rtr_buf_in][OFS_CONTROL][CTL_TX_REQUEST] <= 1'b1;
      end
      if (tx_done_in && tx_buf_in < 3'(NBUF)) begin
        mem_q[tx_buf_in][OFS_CONTROL][CTL_TX_REQUEST] <= 1'b0;
      end
    end
  end

  // transmit done flags: hardware set beats firmware clear
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      done_q <= 6'h00;
    end else begin
      for (int b = 0; b < NBUF; b++) begin
        if (tx_done_in && tx_buf_in == 3'(b)) begin
          done_q[b] <= 1'b1;
        end else if (take_write && req.address == IDX_STATUS && req.writedata[b]) begin
          done_q[b] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  function automatic logic [7:0] irq_en_view(input logic [7:0] v, input can_mode_e m);
    irq_en_view = v;
    if (m != MODE_LEGACY) begin
      irq_en_view[IE_TXB1] = 1'b0;
      irq_en_view[IE_TXB0] = 1'b0;
    end
    if (m == MODE_ENHANCED) begin
      irq_en_view[IE_RXB0] = 1'b0;
    end
  endfunction

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (take_read) begin
      rdata_q <= 32'h0000_0000;
      case (req.address)
        IDX_MAIN_CTRL: rdata_q[7:0] <= main_ctrl_q;
        IDX_DIR_SEL: rdata_q[5:0] <= dir_sel_q;
        IDX_MASK_SEL: rdata_q[7:0] <= enhanced ? mask_sel_q : 8'h00;
        IDX_IRQ_EN: rdata_q[7:0] <= irq_en_view(irq_en_q, mode);
        IDX_STATUS: rdata_q[5:0] <= done_q;
        default: begin
          if (buf_hit) begin
            rdata_q[7:0] <= mem_q[wbuf][wofs];
          end
        end
      endcase
    end
  end
  assign avs_readdata_out = rdata_q;

  // ------------------------------------------------------------
  // outputs to the engine
  // ------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < 6; b++) begin
      if (b < NBUF) begin
        tx_pending_out[b] = dir_sel_q[b] && mem_q[b][OFS_CONTROL][CTL_TX_REQUEST];
        rx_full_out[b] = !dir_sel_q[b] && mem_q[b][OFS_CONTROL][CTL_FULL];
      end else begin
        tx_pending_out[b] = 1'b0;
        rx_full_out[b] = 1'b0;
      end
    end
  end
  assign tx_done_flags_out = done_q;

  // legacy: bit 4 gates buffer 2, bit 0 gates receive buffer 0 via full
  always_comb begin
    if (mode == MODE_LEGACY) begin
      tx_irq_out = (irq_en_q[IE_TXB2] && done_q[2])
        || (irq_en_q[IE_RXB0] && rx_full_out[0]);
    end else begin
      tx_irq_out = irq_en_q[IE_TXB2] && (|done_q);
    end
  end

  mask_route u_mask_route (
    .mask_select_in(mask_sel_q),
    .enhanced_in(enhanced),
    .filter_route_out(filter_route_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // snapshot of a refused write, so the next cycle can show that nothing moved;
  // a done pulse may legally clear the request bit, so that cycle is skipped
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      lock_seen_q <= 1'b0;
      lock_old_q <= 8'h00;
      lock_buf_q <= 3'h0;
      lock_ofs_q <= 4'h0;
    end else begin
      lock_seen_q <= take_write && buf_hit && buf_locked && !rx_load_in && !tx_done_in;
      lock_old_q <= mem_q[wbuf][wofs];
      lock_buf_q <= wbuf;
      lock_ofs_q <= wofs;
    end
  end

  sequence s_rtr_arm(int b);
    rtr_hit_in && rtr_buf_in == 3'(b) && enhanced && dir_sel_q[b]
      && mem_q[b][OFS_CONTROL][CTL_AUTO_REPLY] && !tx_done_in && !take_write;
  endsequence

  AST_RTR_SETS_REQ: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_rtr_arm(2) |=> tx_pending_out[2]) else $error("auto reply did not set request");
  AST_DONE_CLEARS: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    tx_done_in && tx_buf_in == 3'h2 |=> !tx_pending_out[2] && done_q[2])
    else $error("transmit done not recorded");
  AST_LOCKED_WRITE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    lock_seen_q |-> mem_q[lock_buf_q][lock_ofs_q] == lock_old_q)
    else $error("write landed in locked buffer");
  AST_RESET_RX: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $past(reset_in) |-> dir_sel_q == 6'h00) else $error("buffer not receive after reset");
  AST_FULL_SET: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    rx_load_in && enhanced && rx_buf_in == 3'h1 && !dir_sel_q[1] && rx_byte_idx_in == OFS_CONTROL
      && !take_write |=> rx_full_out[1]) else $error("full flag not set");
  AST_IE_ZERO: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    take_read && req.address == IDX_IRQ_EN && enhanced |=> rdata_q[IE_TXB1:IE_TXB0] == 2'h0)
    else $error("tx enables not zero");
  AST_IE_B0: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    take_read && req.address == IDX_IRQ_EN && mode == MODE_ENHANCED |=> !rdata_q[IE_RXB0])
    else $error("bit 0 not zero in mode 1");
  AST_MASK_LEGACY: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !enhanced |-> filter_route_out == 8'h00) else $error("mask select active in legacy");
  AST_IRQ_TX2: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    mode == MODE_LEGACY && !irq_en_q[IE_TXB2] && !irq_en_q[IE_RXB0] |-> !tx_irq_out)
    else $error("interrupt while disabled");
  AST_ANSWER: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(avs_read_in) && state_q == BUS_IDLE |=> !avs_waitrequest_out)
    else $error("bus answer late");
endmodule

// ---- test/can_node_model.sv ----
// behavioural model of the protocol engine and the remote nodes on the bus
// assumes the buffer block samples every event pulse on the rising clock edge
`timescale 1ns/1ps
module can_node_model (
  // clock
  input wire logic sys_clk_in,
  // pending transmit requests from the buffers
  input wire logic [5:0] tx_pending_in,
  // events toward the buffers
  output logic rtr_hit_out,
  output logic [2:0] rtr_buf_out,
  output logic tx_done_out,
  output logic [2:0] tx_buf_out,
  output logic rx_load_out,
  output logic [2:0] rx_buf_out,
  output logic [7:0] rx_byte_out,
  output logic [3:0] rx_byte_idx_out
);
  // idle index lines carry junk (all ones at start, then the complement of the last index) so a stale index is not held
  initial begin
    {rtr_hit_out, tx_done_out, rx_load_out} = 3'h0;
    {rtr_buf_out, tx_buf_out, rx_buf_out} = 9'h1FF;
    {rx_byte_out, rx_byte_idx_out} = 12'hFFF;
  end
  // remote request that matched a filter linked to buffer b
  task automatic send_rtr(input logic [2:0] b);
    rtr_hit_out <= 1'b1;
    rtr_buf_out <= b;
    @(posedge sys_clk_in);
    rtr_hit_out <= 1'b0;
    rtr_buf_out <= ~b;
  endtask
  // one byte moved from the assembly buffer into buffer b
  task automatic load_byte(input logic [2:0] b, input logic [3:0] k, input logic [7:0] v);
    {rx_load_out, rx_buf_out, rx_byte_idx_out, rx_byte_out} <= {1'b1, b, k, v};
    @(posedge sys_clk_in);
    {rx_load_out, rx_buf_out, rx_byte_idx_out, rx_byte_out} <= {1'b0, ~b, ~k, ~v};
  endtask
  // bus is busy for gap cycles, then the lowest pending buffer goes out
  task automatic send_pending(input int gap);
    logic [2:0] sel;
    repeat (gap) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    sel = 3'h7;
    for (int i = 5; i >= 0; i--) if (tx_pending_in[i]) sel = 3'(i);
    @(posedge sys_clk_in);
    tx_done_out <= 1'b1;
    tx_buf_out <= sel;
    @(posedge sys_clk_in);
    tx_done_out <= 1'b0;
    tx_buf_out <= ~sel;
  endtask
endmodule

// ---- test/can_prog_buffers_auto_rtr_bench.sv ----
// self-checking bench for the programmable buffers over avalon-mm
// assumes the designer's one-wait-cycle slave and the node model beside it
`timescale 1ns/1ps
module can_prog_buffers_auto_rtr_bench;
  import prog_buf_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic rtr_hit, tx_done, rx_load;
  logic [2:0] rtr_buf, tx_buf, rx_buf;
  logic [7:0] rx_byte;
  logic [3:0] rx_byte_idx;
  logic [5:0] tx_pending_out, tx_done_flags_out, rx_full_out;
  logic [7:0] filter_route_out;
  logic tx_irq_out;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  always #50 sys_clk_in = ~sys_clk_in;
  prog_buffers #(.NBUF(NUM_BUFS)) DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .rtr_hit_in(rtr_hit), .rtr_buf_in(rtr_buf), .tx_done_in(tx_done), .tx_buf_in(tx_buf),
    .rx_load_in(rx_load), .rx_buf_in(rx_buf), .rx_byte_in(rx_byte),
    .rx_byte_idx_in(rx_byte_idx), .tx_pending_out(tx_pending_out),
    .tx_done_flags_out(tx_done_flags_out), .rx_full_out(rx_full_out),
    .filter_route_out(filter_route_out), .tx_irq_out(tx_irq_out));
  can_node_model node (.sys_clk_in(sys_clk_in), .tx_pending_in(tx_pending_out),
    .rtr_hit_out(rtr_hit), .rtr_buf_out(rtr_buf), .tx_done_out(tx_done),
    .tx_buf_out(tx_buf), .rx_load_out(rx_load), .rx_buf_out(rx_buf),
    .rx_byte_out(rx_byte), .rx_byte_idx_out(rx_byte_idx));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hang in any wait ends the run through the same report
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // the request stands until waitrequest is seen low at a rising edge;
  // read data is taken at that same edge, and only then is anything released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, exp});
  endtask
  function automatic logic [7:0] ba(input int n, input int k);
    return IDX_BUF_BASE + 8'(n) * BUF_STRIDE + 8'(k);
  endfunction
  // port flags are looked at mid-cycle, then the bench resumes on a rising edge
  task automatic port_chk(input logic [31:0] got, input logic [31:0] exp);
    check(got, exp);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    rd_chk(IDX_IRQ_EN, IRQ_EN_RST);
    rd_chk(IDX_DIR_SEL, 8'h00);
    rd_chk(ba(0, 6), 8'h00);
    wr(IDX_MASK_SEL, 8'hFF);
    wr(IDX_IRQ_EN, 8'hFF);
    rd_chk(IDX_IRQ_EN, 8'hFF);
    @(negedge sys_clk_in);
    port_chk({24'h0, filter_route_out}, 32'h0);
    @(posedge sys_clk_in);
    wr(IDX_MAIN_CTRL, {1'b0, MODE_ENHANCED, 5'h00});
    rd_chk(IDX_MASK_SEL, MASK_SEL_RST);
    rd_chk(IDX_IRQ_EN, 8'hF2);
    // every mask code on all four filters at once
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MASK_SEL, {4{2'(c)}});
      rd_chk(IDX_MASK_SEL, {4{2'(c)}});
      @(negedge sys_clk_in);
      port_chk({24'h0, filter_route_out}, {24'h0, {4{2'(c)}}});
      @(posedge sys_clk_in);
    end
    wr(IDX_MAIN_CTRL, {1'b0, MODE_FIFO, 5'h00});
    wr(IDX_IRQ_EN, 8'hFF);
    rd_chk(IDX_IRQ_EN, 8'hF3);
    wr(IDX_MAIN_CTRL, {1'b0, MODE_ENHANCED, 5'h00});
    wr(IDX_IRQ_EN, 8'h10);
    $display("test registers done");
    // identifier, length and data bytes of one buffer, then the gap past them
    for (int k = 1; k < BUF_BYTES; k++) wr(ba(0, k), 8'h40 + 8'(k));
    for (int k = 1; k < BUF_BYTES; k++) rd_chk(ba(0, k), 8'h40 + 8'(k));
    rd_chk(ba(0, 14), 8'h00);
    rd_chk(ba(5, 15), 8'h00);
    $display("test layout done");
    // auto reply on buffer 2, preloaded first; buffer 3 stays receive
    wr(IDX_DIR_SEL, 8'h04);
    wr(ba(2, OFS_LENGTH), 8'h01);
    wr(ba(2, 6), 8'hA5);
    node.send_rtr(3'h2);
    wr(ba(2, OFS_CONTROL), 8'h04);
    wr(ba(3, OFS_CONTROL), 8'h04);
    node.send_rtr(3'h3);
    rd_chk(ba(2, OFS_CONTROL), 8'h04);
    node.send_rtr(3'h2);
    @(negedge sys_clk_in);
    port_chk({26'h0, tx_pending_out}, 32'h04);
    @(posedge sys_clk_in);
    rd_chk(ba(2, OFS_CONTROL), 8'h0C);
    wr(ba(2, 6), 8'h00);
    rd_chk(ba(2, 6), 8'hA5);
    node.send_pending(4);
    @(negedge sys_clk_in);
    port_chk({26'h0, tx_pending_out}, 32'h00);
    port_chk({26'h0, tx_done_flags_out}, 32'h04);
    port_chk({31'h0, tx_irq_out}, 32'h1);
    @(posedge sys_clk_in);
    rd_chk(ba(2, OFS_CONTROL), 8'h04);
    rd_chk(IDX_STATUS, 8'h04);
    wr(IDX_STATUS, 8'h04);
    rd_chk(IDX_STATUS, 8'h00);
    @(negedge sys_clk_in);
    port_chk({31'h0, tx_irq_out}, 32'h0);
    @(posedge sys_clk_in);
    wr(ba(2, 6), 8'h11);
    rd_chk(ba(2, 6), 8'h11);
    $display("test auto reply done");
    // receive lockout, free access order, fifo pointer redirect
    node.load_byte(3'h1, 4'h6, 8'h5A);
    node.load_byte(3'h1, 4'h0, 8'h00);
    @(negedge sys_clk_in);
    port_chk({26'h0, rx_full_out}, 32'h02);
    @(posedge sys_clk_in);
    node.load_byte(3'h1, 4'h6, 8'h77);
    rd_chk(ba(1, 6), 8'h5A);
    rd_chk(ba(0, 6), 8'h46);
    wr(IDX_MAIN_CTRL, {1'b0, MODE_FIFO, 5'h01});
    rd_chk(ba(0, 6), 8'h5A);
    wr(IDX_MAIN_CTRL, {1'b0, MODE_FIFO, 5'h00});
    rd_chk(ba(1, 6), 8'h46);
    wr(IDX_MAIN_CTRL, {1'b0, MODE_ENHANCED, 5'h00});
    wr(ba(1, OFS_CONTROL), 8'h00);
    @(negedge sys_clk_in);
    port_chk({26'h0, rx_full_out}, 32'h00);
    @(posedge sys_clk_in);
    node.load_byte(3'h1, 4'h6, 8'h77);
    rd_chk(ba(1, 6), 8'h77);
    wr(IDX_MAIN_CTRL, {1'b0, MODE_LEGACY, 5'h00});
    rd_chk(ba(1, 6), 8'h00);
    $display("test receive done");
    finish_test();
  end
endmodule
